// [logic/sbc_standby_ctrl.sv]
// Purpose: Halt state, clock-stop gating, enable-pin reset and key latch.
// Assumes: All inputs synchronous to clk_in; registers reached by the
//          device's register-file and peripheral ports.
// Notes:   Reset request is a one-cycle pulse aligned to a carry tick.
`timescale 1ns/1ns
`include "sbc_params.svh"

//////////////////////////////////////////////////////////////////////////////
// How it works
// - Clock stop only when enable pin low.
// - Clock stop with pin high is no-op.
// - Pin rising edge resets at next carry.
// - Pin levels shorter than filter ignored.
// - Filtered pin level readable at 07H.
// - Unused level register bits read zero.
// - Halt freezes CPU until release.
// - Peripherals keep running while halted.
// - Halt works regardless of pin level.
// - Four-bit mask selects release sources.
// - Any enabled condition releases halt.
// - Resume at instruction after halt.
// - Zero mask releases only by reset.
// - Key release on any high key.
// - Key source disabled gives pull-downs.
// - Key source data register at 42H.
// - Multiplexed latch samples during key-source only.
// - Segment high without source bit ignored.
// - Converter pin cut off, latch holds.
// - Key pins also general inputs with pull-downs.
// - Carry flag sets at fixed interval.
// - Interrupt release needs enable, permit, request.
module sbc_standby_ctrl #(
  parameter int FILTER_CYC = `SBC_FILTER_CYC
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  enable_pin_in,
  input  wire logic [3:0]            key_input_pin_in,
  input  wire logic                  key_source_phase_in,
  input  wire logic                  adc_sel_valid_in,
  input  wire logic [1:0]            adc_sel_in,
  input  wire logic                  timer_carry_flag_in,
  input  wire logic                  global_int_enable_in,
  input  wire logic [1:0]            int_permit_in,
  input  wire logic [1:0]            int_request_in,
  input  wire sbc_pkg::sbc_instr_t   instr_in,
  input  wire sbc_pkg::sbc_reg_req_t reg_in,
  output logic [3:0]                 reg_rdata_out,
  output logic                       cpu_hold_out,
  output logic                       halt_resume_out,
  output logic                       clock_stop_out,
  output logic                       enable_reset_out,
  output logic [3:0]                 key_pulldown_out,
  output logic [3:0]                 key_source_data_out
);
  //////////////////////////////////////////////////////////////////////////
  sbc_pkg::sbc_state_t state_ff;
  sbc_pkg::sbc_state_t nxt_state;
  logic [3:0] mask_ff;
  logic [3:0] lcd_mode_ff;
  logic [3:0] key_src_ff;
  logic [3:0] key_latch_ff;
  logic [3:0] rdata_ff;
  logic       level_d_ff;
  logic       rst_pend_ff;
  logic       hold_ff;
  logic       resume_ff;
  logic       stop_ff;
  logic       erst_ff;
  logic [3:0] pull_ff;
  logic       level;

  sbc_level_filter #(
    .CYCLES (FILTER_CYC)
  ) u_filter (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (clk_en_in),
    .raw_in    (enable_pin_in),
    .level_out (level)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register decode.
  wire logic wr_lcd   = reg_in.wr && reg_in.addr == `SBC_ADDR_LCD_MODE;
  wire logic wr_ksrc  = reg_in.wr && reg_in.addr == `SBC_ADDR_KEY_SRC;
  wire logic ks_en    = lcd_mode_ff[`SBC_BIT_KEY_SRC_EN];
  wire logic [3:0] level_word = {3'b000, level};
  wire logic [3:0] nxt_rdata =
      (reg_in.addr == `SBC_ADDR_PIN_LEVEL) ? level_word :
      (reg_in.addr == `SBC_ADDR_LCD_MODE)  ? lcd_mode_ff :
      (reg_in.addr == `SBC_ADDR_KEY_SRC)   ? key_src_ff : 4'h0;

  //////////////////////////////////////////////////////////////////////////
  // Key latch: multiplexed mode samples only pins with a source bit set
  // during the key-source phase; the converter pin is cut off and keeps
  // whatever it last held, so a stale high can release halt at once.
  wire logic [3:0] adc_cut = adc_sel_valid_in ? (4'h1 << adc_sel_in) : 4'h0;
  wire logic [3:0] sample_en = ks_en ? (key_src_ff & {4{key_source_phase_in}})
                                     : 4'hf;
  wire logic [3:0] take = sample_en & ~adc_cut;
  wire logic [3:0] nxt_latch = (key_latch_ff & ~take) | (key_input_pin_in & take);
  wire logic [3:0] nxt_pull = ks_en ? {4{key_source_phase_in}} : 4'hf;

  //////////////////////////////////////////////////////////////////////////
  // Release conditions.
  wire logic key_hit   = mask_ff[`SBC_MASK_KEY] && |key_latch_ff;
  wire logic carry_hit = mask_ff[`SBC_MASK_CARRY] && timer_carry_flag_in;
  wire logic int_hit   = mask_ff[`SBC_MASK_INTR] && global_int_enable_in
                         && |(int_permit_in & int_request_in);
  wire logic release_hit = key_hit || carry_hit || int_hit;
  wire logic rise = level && !level_d_ff;
  wire logic fire_rst = (rst_pend_ff || rise) && timer_carry_flag_in;
  wire logic [3:0] instr_mask = {1'b0, instr_in.mask[2:0] & 3'b011}
                                | {instr_in.mask[3], 3'b000};

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      sbc_pkg::SBC_RUN:
        if (instr_in.halt)
          nxt_state = sbc_pkg::SBC_HALT;
      sbc_pkg::SBC_HALT:
        if (release_hit)
          nxt_state = sbc_pkg::SBC_RUN;
      sbc_pkg::SBC_RST:
        nxt_state = sbc_pkg::SBC_RUN;
      default:
        nxt_state = sbc_pkg::SBC_RUN;
    endcase
    if (fire_rst)
      nxt_state = sbc_pkg::SBC_RST;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff     <= sbc_pkg::SBC_RUN;
      mask_ff      <= 4'h0;
      lcd_mode_ff  <= `SBC_LCD_RESET;
      key_src_ff   <= `SBC_KEY_SRC_RESET;
      key_latch_ff <= 4'h0;
      rdata_ff     <= 4'h0;
      level_d_ff   <= 1'b0;
      rst_pend_ff  <= 1'b0;
      hold_ff      <= 1'b0;
      resume_ff    <= 1'b0;
      stop_ff      <= 1'b0;
      erst_ff      <= 1'b0;
      pull_ff      <= 4'hf;
    end
    else if (clk_en_in)
    begin
      state_ff     <= nxt_state;
      if (state_ff == sbc_pkg::SBC_RUN && instr_in.halt)
        mask_ff <= instr_mask;
      if (wr_lcd)
        lcd_mode_ff <= reg_in.wdata;
      if (wr_ksrc)
        key_src_ff <= reg_in.wdata;
      key_latch_ff <= nxt_latch;
      if (reg_in.rd)
        rdata_ff <= nxt_rdata;
      level_d_ff   <= level;
      rst_pend_ff  <= !fire_rst && (rst_pend_ff || rise);
      hold_ff      <= nxt_state == sbc_pkg::SBC_HALT;
      resume_ff    <= state_ff == sbc_pkg::SBC_HALT && nxt_state == sbc_pkg::SBC_RUN;
      stop_ff      <= instr_in.stop && !level;
      erst_ff      <= fire_rst;
      pull_ff      <= nxt_pull;
    end
  end

  assign reg_rdata_out       = rdata_ff;
  assign cpu_hold_out        = hold_ff;
  assign halt_resume_out     = resume_ff;
  assign clock_stop_out      = stop_ff;
  assign enable_reset_out    = erst_ff;
  assign key_pulldown_out    = pull_ff;
  assign key_source_data_out = key_src_ff;

  //////////////////////////////////////////////////////////////////////////
  property p_stop_gated;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && instr_in.stop && level |=> !clock_stop_out;
  endproperty
  a_stop_gated: assert property (p_stop_gated) else $error("stop taken with pin high");

  property p_stop_low;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && instr_in.stop && !level |=> clock_stop_out;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stop lost with pin low");

  property p_reset_on_carry;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && $rose(enable_reset_out) |-> $past(timer_carry_flag_in);
  endproperty
  a_reset_on_carry: assert property (p_reset_on_carry) else $error("reset off carry");

  property p_level_reg;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && reg_in.rd && reg_in.addr == `SBC_ADDR_PIN_LEVEL
      |=> reg_rdata_out[3:1] == 3'b000 && reg_rdata_out[0] == $past(level);
  endproperty
  a_level_reg: assert property (p_level_reg) else $error("level register wrong");

  property p_halt_enter;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && state_ff == sbc_pkg::SBC_RUN && instr_in.halt && !fire_rst
      |=> cpu_hold_out;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");

  property p_release;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && state_ff == sbc_pkg::SBC_HALT && release_hit && !fire_rst
      |=> !cpu_hold_out && halt_resume_out;
  endproperty
  a_release: assert property (p_release) else $error("halt not released");

  property p_zero_mask;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && state_ff == sbc_pkg::SBC_HALT && mask_ff == 4'h0 && !fire_rst
      |=> state_ff == sbc_pkg::SBC_HALT;
  endproperty
  a_zero_mask: assert property (p_zero_mask) else $error("zero mask released");

  property p_mask_bit2;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && state_ff == sbc_pkg::SBC_RUN && instr_in.halt
      |=> mask_ff == {$past(instr_in.mask[3]), 1'b0, $past(instr_in.mask[1:0])};
  endproperty
  a_mask_bit2: assert property (p_mask_bit2) else $error("unused mask bit set");

  property p_pulldown;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && !ks_en |=> key_pulldown_out == 4'hf;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-downs off");

  property p_level_steady;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && enable_pin_in == level |=> level == $past(level);
  endproperty
  a_level_steady: assert property (p_level_steady) else $error("level moved");

  property p_key_follow;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && !ks_en && !adc_sel_valid_in |=> key_latch_ff == $past(key_input_pin_in);
  endproperty
  a_key_follow: assert property (p_key_follow) else $error("key latch lost pin");

  property p_seg_isolate;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && ks_en && !key_source_phase_in |=> key_latch_ff == $past(key_latch_ff);
  endproperty
  a_seg_isolate: assert property (p_seg_isolate) else $error("latch moved in segment");

  property p_src_only;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && ks_en
      |=> (key_latch_ff & ~$past(key_src_ff)) == ($past(key_latch_ff) & ~$past(key_src_ff));
  endproperty
  a_src_only: assert property (p_src_only) else $error("non-source pin latched");

  property p_adc_hold;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && adc_sel_valid_in
      |=> (key_latch_ff & $past(adc_cut)) == ($past(key_latch_ff) & $past(adc_cut));
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("converter pin latched");

  property p_pull_phase;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && ks_en |=> key_pulldown_out == {4{$past(key_source_phase_in)}};
  endproperty
  a_pull_phase: assert property (p_pull_phase) else $error("pull-downs off phase");

  property p_carry_release;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && state_ff == sbc_pkg::SBC_HALT && mask_ff[`SBC_MASK_CARRY]
      && timer_carry_flag_in && !fire_rst |=> halt_resume_out;
  endproperty
  a_carry_release: assert property (p_carry_release) else $error("carry missed");

  // Only an enabled and permitted request may end a halt that waits for interrupts.
  property p_int_gate;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && state_ff == sbc_pkg::SBC_HALT && !key_hit && !carry_hit
      && !(global_int_enable_in && |(int_permit_in & int_request_in)) && !fire_rst
      |=> cpu_hold_out;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("unpermitted release");

  property p_reset_clears;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && fire_rst |=> enable_reset_out && !cpu_hold_out;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left halt");

  property p_resume_pulse;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && halt_resume_out |=> !halt_resume_out;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume too long");
endmodule : sbc_standby_ctrl

// [include/sbc_params.svh]
// Purpose: Constants for the standby, halt and enable-pin control block.
// Assumes: 10 MHz system clock, 4-bit register file words.
// Notes:   Offsets are register-file and peripheral addresses.
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
`define SBC_ADDR_PIN_LEVEL   8'h07
`define SBC_ADDR_LCD_MODE    8'h10
`define SBC_ADDR_KEY_SRC     8'h42
`define SBC_BIT_LEVEL        0
`define SBC_BIT_KEY_SRC_EN   0
`define SBC_MASK_KEY         0
`define SBC_MASK_CARRY       1
`define SBC_MASK_INTR        3
`define SBC_CLK_HZ           10000000
`define SBC_FILTER_MIN_US    110
`define SBC_FILTER_MAX_US    165
`define SBC_FILTER_CYC       ((`SBC_FILTER_MIN_US * (`SBC_CLK_HZ / 1000000)))
`define SBC_LCD_RESET        4'h0
`define SBC_KEY_SRC_RESET    4'h0
`endif

// [include/sbc_pkg.sv]
// Purpose: Types shared by the standby control block.
// Assumes: Nothing beyond the header.
// Notes:   Release mask layout is key, carry, unused, interrupt.
package sbc_pkg;
  typedef enum logic [1:0] {
    SBC_RUN  = 2'b00,
    SBC_HALT = 2'b01,
    SBC_RST  = 2'b10
  } sbc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [3:0] wdata;
  } sbc_reg_req_t;

  typedef struct packed {
    logic       halt;
    logic       stop;
    logic [3:0] mask;
  } sbc_instr_t;
endpackage : sbc_pkg

// [logic/sbc_level_filter.sv]
// Purpose: Accepts a level only after it has held for the filter time.
// Assumes: Input synchronous to clk_in.
// Notes:   Shorter pulses of either level are dropped.
`timescale 1ns/1ns
module sbc_level_filter #(
  parameter int CYCLES = 1100
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic raw_in,
  output logic      level_out
);
  logic [$clog2(CYCLES+1)-1:0] cnt_ff;
  logic                        level_ff;
  wire logic differs = raw_in != level_ff;
  wire logic done    = cnt_ff == ($clog2(CYCLES+1))'(CYCLES - 1);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt_ff   <= '0;
      level_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!differs)
        cnt_ff <= '0;
      else if (done)
      begin
        cnt_ff   <= '0;
        level_ff <= raw_in;
      end
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign level_out = level_ff;
endmodule : sbc_level_filter

// [tb/sbc_far_side.sv]
// Purpose: Far side: enable pin source, key pins and timer carry tick.
// Assumes: Outputs change at the falling edge.
// Notes:   Carry is a one-cycle tick every PERIOD cycles.
`timescale 1ns/1ns
module sbc_far_side #(
  parameter int PERIOD = 16
) (
  input  wire logic       clk_in,
  input  wire logic       ce_level_in,
  input  wire logic [3:0] keys_in,
  output logic            enable_pin_out,
  output logic [3:0]      key_pin_out,
  output logic            carry_out = 1'b0
);
  int cnt = 0;
  // The bench moves pin levels at the falling edge; passing them straight
  // through avoids a race between the bench and this model at that edge.
  // Released keys read low because the pins carry pull-downs.
  assign enable_pin_out = ce_level_in;
  assign key_pin_out    = keys_in;
  always @(negedge clk_in)
  begin
    cnt            <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    carry_out      <= (cnt == PERIOD - 1);
  end
endmodule : sbc_far_side

// [tb/tb.sv]
// Purpose: Self-checking bench for the standby control block.
// Assumes: Filter of 4 cycles, carry tick every 16 cycles.
// Notes:   Inputs change at the falling edge only.
`timescale 1ns/1ns
module tb;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  ce_lvl = 1'b0;
  logic [3:0]            keys = 4'h0;
  logic                  phase = 1'b0;
  logic                  gie = 1'b0;
  logic [1:0]            permit = 2'h0;
  logic [1:0]            req = 2'h0;
  sbc_pkg::sbc_instr_t   instr = '0;
  sbc_pkg::sbc_reg_req_t rq = '0;
  logic                  pin, carry, hold, resume, stop, ereset;
  logic [3:0]            kpin, rdata, pulldn, ksd;
  logic                  c1 = 1'b0;
  logic                  ce = 1'b1;
  logic                  adc_v = 1'b0;
  logic [1:0]            adc_s = 2'h0;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  logic [3:0]            masks [2] = '{4'h0, 4'h4};

  sbc_far_side #(.PERIOD(16)) i_far (.clk_in(clk), .ce_level_in(ce_lvl), .keys_in(keys),
    .enable_pin_out(pin), .key_pin_out(kpin), .carry_out(carry));
  sbc_standby_ctrl #(.FILTER_CYC(4)) i_dut (.clk_in(clk), .rst_in(rst), .clk_en_in(ce),
    .enable_pin_in(pin), .key_input_pin_in(kpin), .key_source_phase_in(phase),
    .adc_sel_valid_in(adc_v), .adc_sel_in(adc_s), .timer_carry_flag_in(carry),
    .global_int_enable_in(gie), .int_permit_in(permit), .int_request_in(req),
    .instr_in(instr), .reg_in(rq), .reg_rdata_out(rdata), .cpu_hold_out(hold),
    .halt_resume_out(resume), .clock_stop_out(stop), .enable_reset_out(ereset),
    .key_pulldown_out(pulldn), .key_source_data_out(ksd));

  initial
  begin
    forever #50 clk = ~clk;
  end
  // The block takes the carry at the same edge that launches its reset,
  // so c1 holds the carry that the block sampled at the last edge.
  always @(posedge clk)
  begin
    c1 <= carry;
  end

  ////////////////////////////////////////
  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic reg_op(input logic wr, input logic [7:0] a, input logic [3:0] d);
    @(negedge clk);
    rq = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clk);
    rq = '0;
  endtask : reg_op
  task automatic rd_chk(input logic [7:0] a, input logic [3:0] exp);
    reg_op(1'b0, a, 4'h0);
    check(rdata, exp, "read data");
  endtask : rd_chk
  task automatic issue(input logic h, input logic [3:0] m);
    @(negedge clk);
    instr = '{halt: h, stop: !h, mask: m};
    @(negedge clk);
    instr = '0;
  endtask : issue
  task automatic wait_resume(input int max, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (max)
    begin
      @(negedge clk);
      if (resume === 1'b1)
        seen = 1'b1;
    end
    check({3'h0, seen}, {3'h0, exp}, "halt release");
    if (exp)
      check({3'h0, hold}, 4'h0, "hold after release");
  endtask : wait_resume
  task automatic halt_try(input logic [3:0] m, input logic exp, input int max);
    issue(1'b1, m);
    check({3'h0, hold}, 4'h1, "hold after halt");
    wait_resume(max, exp);
  endtask : halt_try
  task automatic wait_ereset;
    logic seen;
    seen = 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      if (ereset === 1'b1)
      begin
        seen = 1'b1;
        check({3'h0, c1}, 4'h1, "carry before reset");
      end
    end
    check({3'h0, seen}, 4'h1, "enable reset");
    check({3'h0, hold}, 4'h0, "hold after reset");
  endtask : wait_ereset
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////
  initial
  begin
    #(100 * 3000);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check(pulldn, 4'hf, "pull-downs");
    rd_chk(8'h07, 4'h0);
    reg_op(1'b1, 8'h42, 4'ha);
    rd_chk(8'h42, 4'ha);
    check(ksd, 4'ha, "key source data");
    reg_op(1'b1, 8'h07, 4'hf);
    rd_chk(8'h07, 4'h0);
    rd_chk(8'h33, 4'h0);
    issue(1'b0, 4'h0);
    check({3'h0, stop}, 4'h1, "stop with pin low");
    ce_lvl = 1'b1;
    @(negedge clk);
    rd_chk(8'h07, 4'h0);
    ce_lvl = 1'b0;
    repeat (8) @(negedge clk);
    rd_chk(8'h07, 4'h0);
    keys = 4'hf;
    gie = 1'b1;
    permit = 2'h3;
    req = 2'h3;
    // Every source is active, yet masks without enabled sources must hold.
    foreach (masks[i])
    begin
      ce_lvl = 1'b0;
      repeat (8) @(negedge clk);
      halt_try(masks[i], 1'b0, 40);
      ce_lvl = 1'b1;
      wait_ereset();
    end
    rd_chk(8'h07, 4'h1);
    ce_lvl = 1'b0;
    @(negedge clk);
    rd_chk(8'h07, 4'h1);
    ce_lvl = 1'b1;
    rd_chk(8'h07, 4'h1);
    issue(1'b0, 4'h0);
    check({3'h0, stop}, 4'h0, "stop with pin high");
    keys = 4'h0;
    permit = 2'h0;
    req = 2'h1;
    halt_try(4'h8, 1'b0, 10);
    permit = 2'h1;
    wait_resume(10, 1'b1);
    req = 2'h0;
    keys = 4'h2;
    halt_try(4'h1, 1'b1, 10);
    keys = 4'h0;
    halt_try(4'h2, 1'b1, 20);
    halt_try(4'hb, 1'b1, 20);
    reg_op(1'b1, 8'h42, 4'hf);
    reg_op(1'b1, 8'h10, 4'h1);
    repeat (2) @(negedge clk);
    check(pulldn, 4'h0, "pull-downs in segment phase");
    phase = 1'b1;
    repeat (2) @(negedge clk);
    check(pulldn, 4'hf, "pull-downs in key phase");
    phase = 1'b0;
    keys = 4'hf;
    halt_try(4'h1, 1'b0, 8);
    phase = 1'b1;
    wait_resume(8, 1'b1);
    keys = 4'h0;
    reg_op(1'b1, 8'h42, 4'h1);
    keys = 4'h2;
    halt_try(4'h1, 1'b0, 8);
    keys = 4'h1;
    wait_resume(4, 1'b1);
    keys = 4'h2;
    reg_op(1'b1, 8'h10, 4'h0);
    @(negedge clk);
    // Pin 1 goes to the converter while its latch still holds a high.
    adc_v = 1'b1;
    adc_s = 2'h1;
    keys = 4'h0;
    halt_try(4'h1, 1'b1, 4);
    adc_v = 1'b0;
    halt_try(4'h1, 1'b0, 8);
    keys = 4'h4;
    wait_resume(4, 1'b1);
    halt_try(4'h8, 1'b0, 2);
    // A request that arrives while the clock enable is low must wait.
    ce = 1'b0;
    req = 2'h1;
    wait_resume(10, 1'b0);
    check({3'h0, hold}, 4'h1, "hold while frozen");
    ce = 1'b1;
    wait_resume(4, 1'b1);
    finish_test();
  end
endmodule : tb
